/* File: dv/pcc_counter_sva.sv */
// Port checker for the preset counter core.
// Bound from the bench top; single core_clk domain, rst asynchronous.
`timescale 1ns/100ps
module pcc_counter_sva
   import pcc_pkg::*;
#(
   parameter int SLOW_CYC_P = 20,
   parameter int FAST_CYC_P = 4,
   parameter int RST_LONG_P = 30,
   parameter int TICK_CYC_P = 10
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pcc_pkg::DIP_W-1:0] dip_sw,
   input wire logic [3:0] key_out_mode,
   input wire logic [pcc_pkg::TIME_W-1:0] key_time_one,
   input wire logic [pcc_pkg::TIME_W-1:0] key_time_two,
   input wire logic key_dual_sub,
   input wire logic [11:0] variant_modes,
   input wire logic dual_en,
   input wire logic [pcc_pkg::SV_W-1:0] set_value_two,
   input wire logic count_input_first,
   input wire logic reset_first_in,
   input wire logic stage_two_output,
   input wire logic [pcc_pkg::PV_W-1:0] present_value,
   input wire logic [3:0] cfg_out_mode,
   input wire logic [2:0] cfg_dir_mode,
   input wire logic cfg_from_switch,
   input wire logic cfg_reject
);
   logic [1:0] up_reg, up_next;
   logic [DIP_W-1:0] dip_reg, dip_next;
   logic lvl_reg, lvl_next, ready, mode_ok;
   logic [CNT_W-1:0] hi_reg, hi_next, rh_reg, rh_next, sh_reg, sh_next;
   logic [3:0] om_exp;
   int need, t_hi, t_lo;
   assign ready = up_reg == 2'h3;
   assign need = dip_reg[DIP_SPEED] ? FAST_CYC_P : SLOW_CYC_P;
   assign t_hi = (dip_reg[DIP_SHOT] ? int'(SHOT_SHORT_CS) :
      int'(SHOT_LONG_CS)) * TICK_CYC_P + 2;
   assign t_lo = t_hi - TICK_CYC_P - 2;
   assign om_exp = dip_reg[DIP_OM_B] ? (dip_reg[DIP_OM_A] ? OM_5 : OM_3) :
      (dip_reg[DIP_OM_A] ? OM_2 : OM_1);
   assign mode_ok = key_out_mode != 4'h0 && key_out_mode <= OM_12 &&
      variant_modes[key_out_mode - 4'h1];
   // Edge count since release, latched switches, run lengths
   always_comb begin
      up_next = ready ? up_reg : up_reg + 2'h1;
      dip_next = (up_reg == 2'h0) ? dip_sw : dip_reg;
      lvl_next = count_input_first;
      hi_next = hi_reg;
      if (count_input_first) begin
         hi_next = lvl_reg ? hi_reg + 21'h1 : 21'h1;
      end
      rh_next = reset_first_in ? rh_reg + 21'h1 : 21'h0;
      sh_next = stage_two_output ? sh_reg + 21'h1 : 21'h0;
   end
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         up_reg <= 2'h0;
         dip_reg <= 8'h00;
         lvl_reg <= 1'b0;
         hi_reg <= 21'h0;
         rh_reg <= 21'h0;
         sh_reg <= 21'h0;
      end else begin
         up_reg <= up_next;
         dip_reg <= dip_next;
         lvl_reg <= lvl_next;
         hi_reg <= hi_next;
         rh_reg <= rh_next;
         sh_reg <= sh_next;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_switch_src:
   assert property (ready |-> cfg_from_switch == dip_reg[DIP_EN])
      else $error("config source differs from pin one");
   a_switch_mode:
   assert property (ready && cfg_from_switch |-> cfg_out_mode == om_exp)
      else $error("switch output mode wrong");
   a_switch_dir:
   assert property (ready && cfg_from_switch |->
      cfg_dir_mode == (dip_reg[DIP_DIR] ? DIR_DOWN : DIR_UP))
      else $error("switch direction wrong");
   a_count_qual:
   assert property (ready && cfg_from_switch && cfg_dir_mode == DIR_UP &&
      !dual_en && present_value == $past(present_value) + 21'h1 |->
      hi_reg >= need) else $error("short count pulse counted");
   a_no_count:
   assert property (rh_reg > RST_LONG_P + 5 && $stable(set_value_two) |->
      $stable(present_value)) else $error("value moved during reset");
   a_reset_drop:
   assert property (rh_reg > RST_LONG_P + 5 && set_value_two != 20'h0 |->
      !stage_two_output) else $error("output on during reset");
   a_shot_len:
   assert property (ready && cfg_from_switch && !reset_first_in &&
      $fell(stage_two_output) |-> sh_reg >= t_lo && sh_reg <= t_hi)
      else $error("one-shot length wrong");
   a_hold_rej:
   assert property (ready && !cfg_from_switch && $past(variant_modes[8]) &&
      $past(key_out_mode) == OM_9 && $past(key_time_one) == SHOT_HOLD_CS
      |-> cfg_reject) else $error("hold in mode nine accepted");
   a_time_range:
   assert property (ready && !cfg_from_switch &&
      ($past(key_time_two) < SHOT_MIN_CS || $past(key_time_two) > SHOT_MAX_CS)
      |-> cfg_reject) else $error("time out of range accepted");
   a_diff_lim:
   assert property (ready && !cfg_from_switch && $past(dual_en) &&
      $past(key_dual_sub) && $past(key_out_mode) < OM_9 |-> cfg_reject)
      else $error("difference accepted in low mode");
   a_mode_avail:
   assert property (ready && !cfg_from_switch && !$past(mode_ok) |->
      cfg_reject) else $error("unavailable mode accepted");
endmodule

/* File: dv/pcc_counter_tb_top.sv */
// Bench top: power-up switch, key and field scenarios for the core.
// Short count parameters; field model drives the sensor lines.
`timescale 1ns/100ps
module pcc_counter_tb_top;
   import pcc_pkg::*;
   localparam int FAST = 4, SLOW = 20, RS = 5, RL = 30, TK = 10;
   logic core_clk, rst, key_speed_fast, key_rst_short, key_dual_sub;
   logic two_stage_en, dual_en, stage_one_output, stage_two_output;
   logic cfg_from_switch, cfg_reject, pv_overflow, pv_underflow;
   logic count_input_first, count_input_second;
   logic reset_first_in, reset_second_in;
   logic [DIP_W-1:0] dip_sw;
   logic [2:0] key_dir_mode, cfg_dir_mode;
   logic [3:0] key_out_mode, cfg_out_mode;
   logic [TIME_W-1:0] key_time_one, key_time_two;
   logic [11:0] variant_modes;
   logic [SV_W-1:0] set_value_one, set_value_two;
   logic [PV_W-1:0] present_value;
   int error_cnt = 0;
   int num_checks = 0;
   pcc_counter #(.SLOW_CYC_P(SLOW), .FAST_CYC_P(FAST), .RST_LONG_P(RL),
      .RST_SHORT_P(RS), .TICK_CYC_P(TK)) uut (.core_clk, .rst, .dip_sw,
      .key_speed_fast, .key_dir_mode, .key_out_mode, .key_time_one,
      .key_time_two, .key_rst_short, .key_dual_sub, .variant_modes,
      .two_stage_en, .dual_en, .set_value_one, .set_value_two,
      .count_input_first, .count_input_second, .reset_first_in,
      .reset_second_in, .stage_one_output, .stage_two_output,
      .present_value, .cfg_out_mode, .cfg_dir_mode, .cfg_from_switch,
      .cfg_reject, .pv_overflow, .pv_underflow);
   pcc_field field (.core_clk, .count_input_first, .count_input_second,
      .reset_first_in, .reset_second_in);
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic chk(input logic ok, input string m);
      num_checks++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic pwr(input logic [7:0] d);
      rst = 1'b1;
      dip_sw = d;
      cyc(2);
      rst = 1'b0;
      cyc(4);
   endtask
   // Fire a one-shot from a fresh reset, measure its length
   task automatic shot(input int lo, input int hi, input int h);
      int n;
      set_value_two = 20'h00001;
      field.drive(1, RL + 15, RL + 15);
      field.drive(0, h, 0);
      n = 0;
      while (stage_two_output !== 1'b1 && n < 8) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (stage_two_output === 1'b1 && n < hi + 8) begin
         cyc(1);
         n++;
      end
      chk(n >= lo && n <= hi, "one-shot length");
      set_value_two = 20'h00064;
   endtask
   task automatic kchk(input logic [3:0] m, input logic [TIME_W-1:0] t1,
      input logic [TIME_W-1:0] t2, input logic s, input logic [11:0] v,
      input logic r);
      key_out_mode = m;
      key_time_one = t1;
      key_time_two = t2;
      key_dual_sub = s;
      variant_modes = v;
      cyc(3);
      chk(cfg_reject === r, "key reject flag");
      if (r === 1'b0) chk(cfg_out_mode === m, "key output mode");
   endtask
   task automatic t_switch_map();
      logic [3:0] exp [4];
      exp = '{OM_1, OM_2, OM_3, OM_5};
      for (int i = 0; i < 4; i++) begin
         pwr(8'h01 | 8'(i << 3));
         chk(cfg_out_mode === exp[i], "switch mode");
         chk(cfg_from_switch === 1'b1, "switch source");
      end
      pwr(8'h18);
      chk(cfg_from_switch === 1'b0, "pin one off");
   endtask
   task automatic t_fast();
      pwr(8'h73);
      dip_sw = 8'h00;
      cyc(4);
      chk(cfg_out_mode === OM_3 && cfg_from_switch === 1'b1, "frozen");
      field.drive(0, 2, 8);
      chk(present_value === 21'h0, "glitch counted");
      field.drive(0, 6, 8);
      field.drive(0, 6, 8);
      chk(present_value === 21'h2, "fast count");
      field.drive(1, 3, 8);
      chk(present_value === 21'h2, "short reset taken");
      field.drive(1, 8, 8);
      chk(present_value === 21'h0, "reset ignored");
      shot(4 * TK, 5 * TK + 4, FAST + 1);
      set_value_two = 20'h00001;
      field.drive(1, 8, 8);
      field.drive(0, FAST + 1, 0);
      cyc(10);
      chk(stage_two_output === 1'b1, "no one-shot");
      chk(stage_one_output === 1'b1, "stage one not mirrored");
      field.drive(1, RS + 4, 0);
      chk(stage_two_output === 1'b0, "pulse not ended");
      set_value_two = 20'h00064;
      cyc(10);
   endtask
   task automatic t_slow();
      pwr(8'h1D);
      chk(cfg_dir_mode === DIR_DOWN && cfg_out_mode === OM_5, "map");
      field.drive(1, RL + 15, RL + 15);
      chk(present_value === 21'h64, "down reload");
      field.drive(0, SLOW + 5, SLOW + 5);
      chk(present_value === 21'h63, "down count");
      chk(pv_overflow === 1'b0 && pv_underflow === 1'b0, "flag");
      field.drive(1, SLOW, RL + 15);
      chk(present_value === 21'h63, "short reset taken");
      field.drive(0, SLOW / 2, SLOW + 5);
      chk(present_value === 21'h63, "bounce counted");
      shot(49 * TK, 50 * TK + 4, SLOW + 1);
   endtask
   task automatic t_keys();
      key_speed_fast = 1'b0;
      key_rst_short = 1'b0;
      pwr(8'h00);
      for (int i = 0; i < 5; i++) begin
         key_dir_mode = 3'(i);
         cyc(3);
         chk(cfg_dir_mode === 3'(i) && cfg_reject === 1'b0, "key dir");
      end
      key_dir_mode = DC_UP;
      field.drive(1, RL + 15, RL + 15);
      field.drive(0, SLOW / 2, SLOW + 5);
      field.drive(0, SLOW + 5, SLOW + 5);
      chk(present_value === 21'h1, "key rate");
      dual_en = 1'b1;
      kchk(4'h7, 14'h0005, 14'h0005, 1'b0, 12'hFFF, 1'b0);
      kchk(OM_9, SHOT_HOLD_CS, 14'h0005, 1'b0, 12'hFFF, 1'b1);
      kchk(OM_10, SHOT_HOLD_CS, 14'h0005, 1'b0, 12'hFFF, 1'b0);
      kchk(OM_3, 14'h0005, SHOT_HOLD_CS, 1'b0, 12'hFFF, 1'b1);
      kchk(OM_3, 14'h0005, SHOT_MAX_CS, 1'b0, 12'hFFF, 1'b0);
      kchk(OM_3, 14'h0005, 14'h2710, 1'b0, 12'hFFF, 1'b1);
      kchk(OM_3, 14'h0005, 14'h0005, 1'b1, 12'hFFF, 1'b1);
      kchk(OM_12, 14'h0005, 14'h0005, 1'b1, 12'hFFF, 1'b0);
      kchk(OM_3, 14'h0005, 14'h0005, 1'b0, 12'hFFB, 1'b1);
      kchk(4'hD, 14'h0005, 14'h0005, 1'b0, 12'hFFF, 1'b1);
      dual_en = 1'b0;
   endtask
   initial begin
      rst = 1'b1;
      dip_sw = 8'h01;
      key_speed_fast = 1'b1;
      key_dir_mode = DC_UP;
      key_out_mode = OM_1;
      key_time_one = 14'h0005;
      key_time_two = 14'h0005;
      key_rst_short = 1'b1;
      key_dual_sub = 1'b0;
      variant_modes = 12'hFFF;
      two_stage_en = 1'b0;
      dual_en = 1'b0;
      set_value_one = 20'h00064;
      set_value_two = 20'h00064;
      cyc(2);
      t_switch_map();
      t_fast();
      t_slow();
      t_keys();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      error_cnt++;
      report_and_stop();
   end
endmodule
bind pcc_counter pcc_counter_sva #(.SLOW_CYC_P(SLOW_CYC_P),
   .FAST_CYC_P(FAST_CYC_P), .RST_LONG_P(RST_LONG_P),
   .TICK_CYC_P(TICK_CYC_P)) chk (.core_clk, .rst, .dip_sw, .key_out_mode,
   .key_time_one, .key_time_two, .key_dual_sub, .variant_modes, .dual_en,
   .set_value_two, .count_input_first, .reset_first_in, .stage_two_output,
   .present_value, .cfg_out_mode, .cfg_dir_mode, .cfg_from_switch,
   .cfg_reject);

/* File: dv/pcc_field.sv */
// Field side: count sensors and reset contacts in front of the counter.
// Lines change at the falling edge and hold for whole cycles.
`timescale 1ns/100ps
module pcc_field (
   input wire logic core_clk,
   output logic count_input_first,
   output logic count_input_second,
   output logic reset_first_in,
   output logic reset_second_in
);
   initial begin
      count_input_first = 1'b0;
      count_input_second = 1'b0;
      reset_first_in = 1'b0;
      reset_second_in = 1'b0;
   end
   // One pulse on a count line or on both reset contacts
   task automatic drive(input bit rs, input int hi, input int lo);
      @(negedge core_clk);
      if (rs) begin
         reset_first_in = 1'b1;
         reset_second_in = 1'b1;
      end else begin
         count_input_first = 1'b1;
      end
      repeat (hi) @(negedge core_clk);
      reset_first_in = 1'b0;
      reset_second_in = 1'b0;
      count_input_first = 1'b0;
      repeat (lo) @(negedge core_clk);
   endtask
endmodule

/* File: hw/pcc_counter.sv */
// Preset counter core with power-up configuration and output stages.
// Assumes all inputs synchronous to core_clk; rst marks power-on.
`timescale 1ns/100ps
module pcc_counter #(
   parameter int SLOW_CYC_P = pcc_pkg::SLOW_CYC,
   parameter int FAST_CYC_P = pcc_pkg::FAST_CYC,
   parameter int RST_LONG_P = pcc_pkg::RST_LONG_CYC,
   parameter int RST_SHORT_P = pcc_pkg::RST_SHORT_CYC,
   parameter int TICK_CYC_P = pcc_pkg::TICK_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [pcc_pkg::DIP_W-1:0] dip_sw,
   input wire logic key_speed_fast,
   input wire logic [2:0] key_dir_mode,
   input wire logic [3:0] key_out_mode,
   input wire logic [pcc_pkg::TIME_W-1:0] key_time_one,
   input wire logic [pcc_pkg::TIME_W-1:0] key_time_two,
   input wire logic key_rst_short,
   input wire logic key_dual_sub,
   input wire logic [11:0] variant_modes,
   input wire logic two_stage_en,
   input wire logic dual_en,
   input wire logic [pcc_pkg::SV_W-1:0] set_value_one,
   input wire logic [pcc_pkg::SV_W-1:0] set_value_two,
   input wire logic count_input_first,
   input wire logic count_input_second,
   input wire logic reset_first_in,
   input wire logic reset_second_in,
   output logic stage_one_output,
   output logic stage_two_output,
   output logic [pcc_pkg::PV_W-1:0] present_value,
   output logic [3:0] cfg_out_mode,
   output logic [2:0] cfg_dir_mode,
   output logic cfg_from_switch,
   output logic cfg_reject,
   output logic pv_overflow,
   output logic pv_underflow
);
   import pcc_pkg::*;

   // Next value of a present value for one count step
   function automatic logic signed [PV_W-1:0] step(
      input logic signed [PV_W-1:0] v,
      input logic inc,
      input logic dec,
      input logic sat
   );
      logic signed [PV_W-1:0] r;
      r = v;
      if (inc && !dec) begin
         if (v >= PV_TOP) begin
            r = sat ? PV_TOP : PV_ZERO;
         end else begin
            r = v + 21'sh000001;
         end
      end else if (dec && !inc && v > PV_BOTTOM) begin
         r = v - 21'sh000001;
      end
      return r;
   endfunction

   pcc_cfg_e st_reg;
   pcc_cfg_e st_next;
   logic [DIP_W-1:0] dip_reg;
   logic [DIP_W-1:0] dip_next;
   logic fast_reg, fast_next;
   logic rshort_reg, rshort_next;
   logic sub_reg, sub_next;
   logic rej_reg, rej_next;
   pcc_dir_e dir_reg, dir_next;
   logic [3:0] om_reg, om_next;
   logic [TIME_W-1:0] t1_reg, t1_next;
   logic [TIME_W-1:0] t2_reg, t2_next;
   logic [3:0] om_key;
   pcc_dir_e dir_key;

   always_comb begin
      st_next = st_reg;
      dip_next = dip_reg;
      unique case (st_reg)
         CFG_LOAD: begin
            dip_next = dip_sw;
            st_next = CFG_RUN;
         end
         CFG_RUN: begin
            st_next = CFG_RUN;
         end
      endcase
   end

   // Effective settings from one source only
   always_comb begin
      rej_next = 1'b0;
      unique case (key_dir_mode)
         DC_UP: dir_key = DIR_UP;
         DC_DOWN: dir_key = DIR_DOWN;
         DC_UDA: dir_key = DIR_UDA;
         DC_UDB: dir_key = DIR_UDB;
         DC_UDC: dir_key = DIR_UDC;
         default: begin
            dir_key = DIR_UP;
            rej_next = 1'b1;
         end
      endcase
      // Mode must exist on this variant
      om_key = key_out_mode;
      if (key_out_mode < OM_1 || key_out_mode > OM_12 ||
          !variant_modes[4'(key_out_mode - OM_1)]) begin
         om_key = OM_1;
         rej_next = 1'b1;
      end
      if (dip_reg[DIP_EN]) begin
         fast_next = dip_reg[DIP_SPEED];
         dir_next = dip_reg[DIP_DIR] ? DIR_DOWN : DIR_UP;
         unique case ({dip_reg[DIP_OM_B], dip_reg[DIP_OM_A]})
            2'b00: om_next = OM_1;
            2'b01: om_next = OM_2;
            2'b10: om_next = OM_3;
            2'b11: om_next = OM_5;
         endcase
         t2_next = dip_reg[DIP_SHOT] ? SHOT_SHORT_CS : SHOT_LONG_CS;
         t1_next = t2_next;
         rshort_next = dip_reg[DIP_RSTW];
         sub_next = 1'b0;
         rej_next = 1'b0;
      end else begin
         fast_next = key_speed_fast;
         dir_next = dir_key;
         om_next = om_key;
         rshort_next = key_rst_short;
         t2_next = key_time_two;
         if (key_time_two < SHOT_MIN_CS || key_time_two > SHOT_MAX_CS) begin
            t2_next = SHOT_MIN_CS;
            rej_next = 1'b1;
         end
         t1_next = key_time_one;
         if (key_time_one > SHOT_MAX_CS) begin
            t1_next = SHOT_MIN_CS;
            rej_next = 1'b1;
         end
         if (om_key == OM_9 && key_time_one == SHOT_HOLD_CS) begin
            t1_next = SHOT_MIN_CS;
            rej_next = 1'b1;
         end
         sub_next = key_dual_sub;
         if (key_dual_sub && om_key < OM_9) begin
            sub_next = 1'b0;
            rej_next = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_reg <= CFG_LOAD;
         dip_reg <= '0;
         fast_reg <= 1'b0;
         rshort_reg <= 1'b0;
         sub_reg <= 1'b0;
         rej_reg <= 1'b0;
         dir_reg <= DIR_UP;
         om_reg <= OM_1;
         t1_reg <= SHOT_LONG_CS;
         t2_reg <= SHOT_LONG_CS;
      end else begin
         st_reg <= st_next;
         dip_reg <= dip_next;
         fast_reg <= fast_next;
         rshort_reg <= rshort_next;
         sub_reg <= sub_next;
         rej_reg <= rej_next;
         dir_reg <= dir_next;
         om_reg <= om_next;
         t1_reg <= t1_next;
         t2_reg <= t2_next;
      end
   end

   // Input qualification
   logic [CNT_W-1:0] cnt_need;
   logic [CNT_W-1:0] rst_need;
   logic [3:0] raw_in;
   logic [3:0] cln_in;
   assign cnt_need = fast_reg ? CNT_W'(FAST_CYC_P) : CNT_W'(SLOW_CYC_P);
   assign rst_need = rshort_reg ? CNT_W'(RST_SHORT_P) : CNT_W'(RST_LONG_P);
   assign raw_in = {reset_second_in, reset_first_in,
                    count_input_second, count_input_first};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_qual
         pcc_qualify u_q (
            .core_clk(core_clk),
            .rst(rst),
            .raw(raw_in[gi]),
            .need_cyc(gi < 2 ? cnt_need : rst_need),
            .clean(cln_in[gi])
         );
      end
   endgenerate

   // Counting
   logic [1:0] prev_reg, prev_next;
   logic ev1, ev2, rst1, rst2, sat;
   logic inc1, dec1, inc2, dec2;
   logic signed [PV_W-1:0] pv1_reg, pv1_next, pv2_reg, pv2_next;
   logic signed [PV_W-1:0] val, sv1, sv2, start;
   logic done1, done2, done1_reg, done2_reg, ovf_reg, unf_reg;
   logic [SV_W:0] sv1_ext, sv2_ext;

   assign ev1 = cln_in[0] && !prev_reg[0];
   assign ev2 = cln_in[1] && !prev_reg[1];
   assign prev_next = cln_in[1:0];
   assign rst1 = cln_in[2];
   assign rst2 = cln_in[3];
   assign sat = om_reg >= OM_9 || dual_en;
   assign sv1_ext = {1'b0, set_value_one};
   assign sv2_ext = {1'b0, set_value_two};
   assign sv1 = $signed(sv1_ext);
   assign sv2 = $signed(sv2_ext);
   assign start = (dir_reg == DIR_DOWN) ? sv2 : PV_ZERO;

   always_comb begin
      inc1 = 1'b0;
      dec1 = 1'b0;
      inc2 = 1'b0;
      dec2 = 1'b0;
      if (dual_en) begin
         inc1 = ev1 && dir_reg != DIR_DOWN;
         dec1 = ev1 && dir_reg == DIR_DOWN;
         inc2 = ev2 && dir_reg != DIR_DOWN;
         dec2 = ev2 && dir_reg == DIR_DOWN;
      end else begin
         unique case (dir_reg)
            DIR_UP: inc1 = ev1;
            DIR_DOWN: dec1 = ev1;
            DIR_UDA: begin
               inc1 = ev1;
               dec1 = ev2;
            end
            DIR_UDB: begin
               inc1 = ev1 && !cln_in[1];
               dec1 = ev1 && cln_in[1];
            end
            DIR_UDC: begin
               inc1 = ev1 && !cln_in[1];
               dec1 = ev2 && !cln_in[0];
            end
         endcase
      end
      pv1_next = rst1 ? start : step(pv1_reg, inc1, dec1, sat);
      pv2_next = (rst2 || !dual_en) ? PV_ZERO :
                 step(pv2_reg, inc2, dec2, sat);
      // Recycle modes reload on completion
      if (!rst1 && done2 && !done2_reg && om_reg > OM_2 &&
          om_reg < OM_9 && !dual_en) begin
         pv1_next = start;
      end
   end

   assign val = !dual_en ? pv1_reg :
                sub_reg ? pv1_reg - pv2_reg : pv1_reg + pv2_reg;
   assign done2 = (dir_reg == DIR_DOWN) ? val <= PV_ZERO : val >= sv2;
   assign done1 = (dir_reg == DIR_DOWN) ? val <= sv1 : val >= sv1;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         prev_reg <= '0;
         pv1_reg <= PV_ZERO;
         pv2_reg <= PV_ZERO;
         done1_reg <= 1'b0;
         done2_reg <= 1'b0;
         ovf_reg <= 1'b0;
         unf_reg <= 1'b0;
      end else begin
         prev_reg <= prev_next;
         pv1_reg <= pv1_next;
         pv2_reg <= pv2_next;
         done1_reg <= done1 && !rst1;
         done2_reg <= done2 && !rst1;
         ovf_reg <= sat && val >= PV_TOP;
         unf_reg <= val <= PV_BOTTOM;
      end
   end

   // Output stages
   logic tick;
   logic [CNT_W-1:0] tick_reg, tick_next;
   logic shot1, shot2, hold1, hold2;
   logic [TIME_W-1:0] dur1;

   assign tick = tick_reg == CNT_W'(TICK_CYC_P - 1);
   assign tick_next = tick ? '0 : tick_reg + 1'b1;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_next;
      end
   end

   assign hold2 = om_reg < OM_3 || om_reg > OM_9;
   // First stage pulse in modes 10-12 unless t1_reg is SHOT_HOLD_CS
   assign hold1 = om_reg < OM_10 || t1_reg == SHOT_HOLD_CS;
   assign dur1 = t1_reg;

   pcc_oneshot u_shot2 (
      .core_clk(core_clk),
      .rst(rst),
      .start(done2 && !done2_reg && !rst1),
      .stop(rst1),
      .hold(hold2),
      .tick(tick),
      .dur(t2_reg),
      .active(shot2)
   );

   pcc_oneshot u_shot1 (
      .core_clk(core_clk),
      .rst(rst),
      .start(done1 && !done1_reg && !rst1),
      .stop(rst1),
      .hold(hold1),
      .tick(tick),
      .dur(dur1),
      .active(shot1)
   );

   assign stage_two_output = shot2;
   assign stage_one_output = two_stage_en ? shot1 : shot2;
   assign present_value = pv1_reg;
   assign cfg_out_mode = om_reg;
   assign cfg_dir_mode = dir_reg;
   assign cfg_from_switch = dip_reg[DIP_EN];
   assign cfg_reject = rej_reg;
   assign pv_overflow = ovf_reg;
   assign pv_underflow = unf_reg;
endmodule

/* File: hw/pcc_oneshot.sv */
// Output stage: timed pulse of dur ticks, or held when hold is set.
// Assumes tick is a one-cycle pulse every 10 ms.
`timescale 1ns/100ps
module pcc_oneshot (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic stop,
   input wire logic hold,
   input wire logic tick,
   input wire logic [pcc_pkg::TIME_W-1:0] dur,
   output logic active
);
   import pcc_pkg::*;
   logic act_reg;
   logic act_next;
   logic [TIME_W-1:0] left_reg;
   logic [TIME_W-1:0] left_next;

   always_comb begin
      act_next = act_reg;
      left_next = left_reg;
      if (stop) begin
         act_next = 1'b0;
      end else if (start) begin
         act_next = 1'b1;
         left_next = dur;
      end else if (act_reg && !hold && tick) begin
         left_next = left_reg - 1'b1;
         if (left_reg <= SHOT_MIN_CS) begin
            act_next = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         act_reg <= 1'b0;
         left_reg <= '0;
      end else begin
         act_reg <= act_next;
         left_reg <= left_next;
      end
   end

   assign active = act_reg;
endmodule

/* File: hw/pcc_pkg.sv */
// Shared constants and types for the preset counter core and its submodules.
// Assumes a single 100 MHz core clock.
package pcc_pkg;
   localparam int PV_W = 21;
   localparam int SV_W = 20;
   localparam int CNT_W = 21;
   localparam int TIME_W = 14;
   localparam int DIP_W = 8;
   localparam int CLK_HZ = 100_000_000;
   // Present value range, signed
   localparam logic signed [PV_W-1:0] PV_TOP = 21'sh0F423F;
   localparam logic signed [PV_W-1:0] PV_BOTTOM = -21'sh01869F;
   localparam logic signed [PV_W-1:0] PV_ZERO = 21'sh000000;
   // Counting speeds and the stable time they imply
   localparam int SLOW_HZ = 30;
   localparam int FAST_HZ = 5000;
   localparam int SLOW_CYC = (CLK_HZ + 2 * SLOW_HZ - 1) / (2 * SLOW_HZ);
   localparam int FAST_CYC = (CLK_HZ + 2 * FAST_HZ - 1) / (2 * FAST_HZ);
   // Reset input minimum widths
   localparam int RST_LONG_MS = 20;
   localparam int RST_SHORT_MS = 1;
   localparam int RST_LONG_CYC = RST_LONG_MS * (CLK_HZ / 1000);
   localparam int RST_SHORT_CYC = RST_SHORT_MS * (CLK_HZ / 1000);
   // One-shot times in 10 ms units
   localparam int TICK_MS = 10;
   localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
   localparam logic [TIME_W-1:0] SHOT_LONG_CS = 14'h0032;
   localparam logic [TIME_W-1:0] SHOT_SHORT_CS = 14'h0005;
   localparam logic [TIME_W-1:0] SHOT_MIN_CS = 14'h0001;
   localparam logic [TIME_W-1:0] SHOT_MAX_CS = 14'h270F;
   localparam logic [TIME_W-1:0] SHOT_HOLD_CS = 14'h0000;
   // Output modes 1..12
   localparam logic [3:0] OM_1 = 4'h1;
   localparam logic [3:0] OM_2 = 4'h2;
   localparam logic [3:0] OM_3 = 4'h3;
   localparam logic [3:0] OM_5 = 4'h5;
   localparam logic [3:0] OM_9 = 4'h9;
   localparam logic [3:0] OM_10 = 4'hA;
   localparam logic [3:0] OM_12 = 4'hC;
   // Key codes of the direction modes
   localparam logic [2:0] DC_UP = 3'h0;
   localparam logic [2:0] DC_DOWN = 3'h1;
   localparam logic [2:0] DC_UDA = 3'h2;
   localparam logic [2:0] DC_UDB = 3'h3;
   localparam logic [2:0] DC_UDC = 3'h4;
   // Switch pin positions (pin n is bit n-1)
   localparam int DIP_EN = 0;
   localparam int DIP_SPEED = 1;
   localparam int DIP_DIR = 2;
   localparam int DIP_OM_A = 3;
   localparam int DIP_OM_B = 4;
   localparam int DIP_SHOT = 5;
   localparam int DIP_RSTW = 6;
   typedef enum logic [2:0] {
      DIR_UP, DIR_DOWN, DIR_UDA, DIR_UDB, DIR_UDC
   } pcc_dir_e;
   typedef enum logic {CFG_LOAD, CFG_RUN} pcc_cfg_e;
endpackage

/* File: hw/pcc_qualify.sv */
// Input qualifier: the output follows the raw level only after it has
// stood for need_cyc cycles. Assumes raw is synchronous to core_clk.
`timescale 1ns/100ps
module pcc_qualify (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic raw,
   input wire logic [pcc_pkg::CNT_W-1:0] need_cyc,
   output logic clean
);
   import pcc_pkg::*;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   logic clean_reg;
   logic clean_next;

   always_comb begin
      cnt_next = '0;
      clean_next = clean_reg;
      if (raw != clean_reg) begin
         if (cnt_reg + 1'b1 >= need_cyc) begin
            clean_next = raw;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= '0;
         clean_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         clean_reg <= clean_next;
      end
   end

   assign clean = clean_reg;
endmodule
